// ==== tht_pkg.sv ====
// package: constants, register map and states of the thermal throttle
package tht_pkg;

	// core clock rate in MHz
	localparam int CLK_MHZ      = 125;
	// clock stop per ratio step, least time
	localparam int STOP_NS      = 500;
	localparam int STOP_CYC     = (STOP_NS * CLK_MHZ + 999) / 1000;
	// longest whole ratio transition
	localparam int TRANS_NS     = 2000;
	localparam int TRANS_CYC    = TRANS_NS * CLK_MHZ / 1000;
	// wait before the next step down
	localparam int STEP_US      = 1000;
	localparam int STEP_CYC_D   = STEP_US * CLK_MHZ;
	// hysteresis before recovery starts
	localparam int HYST_US      = 100;
	localparam int HYST_CYC_D   = HYST_US * CLK_MHZ;
	// combined gating and ratio time before critical flag
	localparam int CRIT_MS      = 20;
	localparam int CRIT_CYC_D   = CRIT_MS * 1000 * CLK_MHZ;
	// least spacing of two external hot assertions
	localparam int TOG_US       = 1500;
	localparam int TOG_CYC_D    = TOG_US * CLK_MHZ;
	// fixed modulation period and clock-off part (40 % on)
	localparam int MOD_PER_US   = 40;
	localparam int MOD_PER_D    = MOD_PER_US * CLK_MHZ;
	localparam int MOD_OFF_US   = 24;
	localparam int MOD_OFF_D    = MOD_OFF_US * CLK_MHZ;
	// longest clock-off run allowed while modulating
	localparam int OFF_MAX_US   = 32;
	localparam int OFF_MAX_CYC  = OFF_MAX_US * CLK_MHZ;
	// width of the long counters
	localparam int CNT_W        = 22;

	// register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	// control fields and reset value (bidirectional pin)
	localparam int CTRL_INONLY  = 0;
	localparam int CTRL_IE_AS   = 1;
	localparam int CTRL_IE_DE   = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	// status fields
	localparam int ST_CRIT      = 0;
	localparam int ST_EV_AS     = 1;
	localparam int ST_EV_DE     = 2;
	localparam int ST_TCC       = 3;
	localparam int ST_MOD       = 4;
	localparam int ST_EXT       = 5;
	localparam int ST_LOCK      = 6;
	localparam int ST_TRIP      = 7;
	localparam int ST_RATIO_LSB = 8;
	localparam int ST_VC_LSB    = 16;
	localparam int ST_STATE_LSB = 24;

	// throttle sequencer states
	typedef enum logic [3:0] {
		S_IDLE    = 4'h0,
		S_DN_STOP = 4'h1,
		S_DN_VOLT = 4'h2,
		S_WAIT    = 4'h3,
		S_GATE    = 4'h4,
		S_COMB    = 4'h5,
		S_HYST    = 4'h6,
		S_UP_VOLT = 4'h7,
		S_UP_STOP = 4'h8,
		S_EXT     = 4'h9
	} tht_state_e;

endpackage : tht_pkg

// ==== tht_mod_if.sv ====
// interface: modulation request and clock gate between sequencer and generator
`timescale 1ns/1ps
`default_nettype none
interface tht_mod_if;
	logic en;   // modulation wanted
	logic gate; // clocks off now
	modport ctl (output en, input gate);
	modport gen (input en, output gate);
endinterface : tht_mod_if
`default_nettype wire

// ==== tht_clkmod.sv ====
// module: fixed-duty clock modulation generator
`timescale 1ns/1ps
`default_nettype none
module tht_clkmod
	import tht_pkg::*;
#(
	parameter int PER = MOD_PER_D, // period in core cycles
	parameter int OFF = MOD_OFF_D  // clock-off cycles per period
)(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	tht_mod_if.gen    m
);
	localparam int CW = $clog2(PER);

	// generator state
	typedef struct packed {
		logic [CW-1:0] cnt; // position in period
		logic          gate; // clocks off
	} tht_cm_s;

	tht_cm_s s_r;
	tht_cm_s s_nxt;

	// counts core cycles only, so timing ignores the ratio
	always_comb begin
		s_nxt = s_r;
		if (!m.en) begin
			// idle: restart period at an off phase
			s_nxt.cnt  = '0;
			s_nxt.gate = 1'b0;
		end else begin
			s_nxt.cnt  = (s_r.cnt == CW'(PER - 1)) ? '0 : s_r.cnt + 1'b1;
			s_nxt.gate = (s_r.cnt < CW'(OFF));
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign m.gate = s_r.gate;

endmodule : tht_clkmod
`default_nettype wire

// ==== tht_throttle.sv ====
// module: adaptive thermal throttle sequencer with hot pin and bus registers
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tht_throttle
	import tht_pkg::*;
#(
	parameter logic [7:0] RATIO_NOM = 8'h24, // nominal ratio
	parameter logic [7:0] RATIO_MIN = 8'h08, // lowest ratio
	parameter logic [7:0] VC_NOM    = 8'h50, // voltage code at nominal
	parameter logic [7:0] VC_STEP   = 8'h02, // code change per ratio step
	parameter int         STEP_CYC  = STEP_CYC_D,
	parameter int         HYST_CYC  = HYST_CYC_D,
	parameter int         CRIT_CYC  = CRIT_CYC_D,
	parameter int         TOG_CYC   = TOG_CYC_D,
	parameter int         MOD_PER   = MOD_PER_D,
	parameter int         MOD_OFF   = MOD_OFF_D
)(
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic [7:0]  TEMP_OFF,
	input  wire logic        TEMP_HOT5,
	input  wire logic        TEMP_CATA,
	input  wire logic        PROC_HOT_N_I,
	output logic             PROC_HOT_N_O,
	output logic             PROC_HOT_N_OE,
	output logic             THERMAL_TRIP_N,
	output logic             CLK_STOP,
	output logic      [7:0]  RATIO,
	output logic      [7:0]  VCODE,
	output logic             TCC_ACTIVE,
	output logic             PROC_HOT_EVT
);

	// all state of the block outside the modulation generator
	typedef struct packed {
		tht_state_e       st;     // sequencer state
		logic [7:0]       ratio;  // current core ratio
		logic [7:0]       vcode;  // current voltage code
		logic             mod;    // modulation requested
		logic             crit;   // critical temperature flag
		logic [CNT_W-1:0] cnt;    // step, stop and hysteresis timer
		logic [CNT_W-1:0] ccnt;   // combined-active timer
		logic [CNT_W-1:0] tcnt;   // toggle window timer
		logic             tarm;   // toggle window open
		logic             lock;   // minimum state held for good
		logic             trip;   // catastrophic trip latched
		logic [1:0]       hs;     // hot pin synchroniser
		logic [2:0]       drv;    // own drive history
		logic             ext_d;  // external hot, last cycle
		logic [2:0]       ctrl;   // control register
		logic             ev_as;  // pin assertion event
		logic             ev_de;  // pin release event
		logic             wr_pend; // write data phase due
		logic             wr_ctrl; // write targets control
		logic             wr_stat; // write targets status
		logic [31:0]      rdata;  // read data register
		logic [CNT_W-1:0] offc;   // length of current clock-off run
	} tht_top_s;

	localparam tht_top_s RST_S = '{
		st:    S_IDLE,
		ratio: RATIO_NOM,
		vcode: VC_NOM,
		hs:    2'b11,
		ctrl:  CTRL_RST,
		default: '0
	};

	tht_top_s s_r;
	tht_top_s s_nxt;

	// voltage code belonging to a ratio
	function automatic logic [7:0] vc_of(input logic [7:0] r);
		vc_of = VC_NOM - 8'((RATIO_NOM - r) * VC_STEP);
	endfunction : vc_of

	logic        hot;       // reading at activation point
	logic        drive;     // we pull the hot pin low
	logic        ext;       // someone else pulls it low
	logic        ext_rise;  // external assertion edge
	logic        ext_fall;  // external release edge
	logic        acc;       // bus address phase taken
	logic        comb_act;  // gating and minimum ratio both on while the reading is hot
	logic [31:0] ctrl_word; // control as read
	logic [31:0] stat_word; // status as read

	tht_mod_if mif ();

	// modulation generator on the core clock
	tht_clkmod #(
		.PER (MOD_PER),
		.OFF (MOD_OFF)
	) u_clkmod (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.ce    (CE),
		.m     (mif)
	);

	// sensor reports offset below maximum, zero is the trip point
	assign hot = (TEMP_OFF == 8'h00);
	// drive pin only in bidirectional mode and own activation
	assign drive = !s_r.ctrl[CTRL_INONLY] && (s_r.st != S_IDLE) && (s_r.st != S_EXT);
	// ignore low pin while our own drive may still echo back
	assign ext = !s_r.hs[1] && (s_r.drv == 3'h0) && !drive;
	assign ext_rise = ext && !s_r.ext_d;
	assign ext_fall = !ext && s_r.ext_d;
	assign acc = HSEL && HTRANS[1] && HREADY;
	assign comb_act = s_r.mod && (s_r.ratio == RATIO_MIN) && hot;
	assign mif.en = s_r.mod;

	// register read images
	always_comb begin
		ctrl_word = '0;
		ctrl_word[2:0] = s_r.ctrl;
		stat_word = '0;
		stat_word[ST_CRIT] = s_r.crit;
		stat_word[ST_EV_AS] = s_r.ev_as;
		stat_word[ST_EV_DE] = s_r.ev_de;
		stat_word[ST_TCC] = (s_r.st != S_IDLE);
		stat_word[ST_MOD] = s_r.mod;
		stat_word[ST_EXT] = s_r.ext_d;
		stat_word[ST_LOCK] = s_r.lock;
		stat_word[ST_TRIP] = s_r.trip;
		stat_word[ST_RATIO_LSB +: 8] = s_r.ratio;
		stat_word[ST_VC_LSB +: 8] = s_r.vcode;
		stat_word[ST_STATE_LSB +: 4] = s_r.st;
	end

	// next state of the block outside the modulation generator
	always_comb begin
		s_nxt = s_r;
		// pin synchroniser, second flop is the only reader
		s_nxt.hs = {s_r.hs[0], PROC_HOT_N_I};
		s_nxt.drv = {s_r.drv[1:0], drive};
		s_nxt.ext_d = ext;

		// bus: data phase of a write, clears come first
		s_nxt.wr_pend = 1'b0;
		if (s_r.wr_pend && s_r.wr_ctrl) begin
			s_nxt.ctrl = HWDATA[2:0];
		end
		if (s_r.wr_pend && s_r.wr_stat) begin
			// write one to clear sticky bits
			if (HWDATA[ST_CRIT]) s_nxt.crit = 1'b0;
			if (HWDATA[ST_EV_AS]) s_nxt.ev_as = 1'b0;
			if (HWDATA[ST_EV_DE]) s_nxt.ev_de = 1'b0;
		end
		// bus: address phase
		if (acc) begin
			s_nxt.wr_pend = HWRITE;
			s_nxt.wr_ctrl = (HADDR[11:0] == CTRL_OFS);
			s_nxt.wr_stat = (HADDR[11:0] == STAT_OFS);
			if (!HWRITE) begin
				unique case (HADDR[11:0])
					CTRL_OFS: s_nxt.rdata = ctrl_word;
					STAT_OFS: s_nxt.rdata = stat_word;
					default:  s_nxt.rdata = '0; // unmapped reads zero
				endcase
			end
		end

		// pin edge events, set wins over clear
		if (ext_rise && s_r.ctrl[CTRL_IE_AS]) begin
			s_nxt.ev_as = 1'b1;
		end
		if (ext_fall && s_r.ctrl[CTRL_IE_DE]) begin
			s_nxt.ev_de = 1'b1;
		end

		// toggle window after each external assertion
		if (s_r.tarm) begin
			s_nxt.tcnt = s_r.tcnt + 1'b1;
			if (s_r.tcnt == CNT_W'(TOG_CYC - 1)) begin
				s_nxt.tarm = 1'b0;
			end
		end
		if (ext_rise) begin
			// second assertion inside window locks minimum
			if (s_r.tarm) s_nxt.lock = 1'b1;
			s_nxt.tarm = 1'b1;
			s_nxt.tcnt = '0;
		end

		// catastrophic trip latches until reset
		if (TEMP_CATA) begin
			s_nxt.trip = 1'b1;
		end

		// off run length, kept for the limit check only
		s_nxt.offc = mif.gate ? s_r.offc + 1'b1 : '0;

		// combined time, flag when it exceeds the limit
		if (comb_act) begin
			if (s_r.ccnt == CNT_W'(CRIT_CYC)) begin
				s_nxt.crit = 1'b1;
			end else begin
				s_nxt.ccnt = s_r.ccnt + 1'b1;
			end
		end else begin
			s_nxt.ccnt = '0;
		end

		// sequencer
		if (ext || s_r.lock) begin
			// external hot: straight to minimum, no gating
			s_nxt.st = S_EXT;
			s_nxt.ratio = RATIO_MIN;
			s_nxt.vcode = vc_of(RATIO_MIN);
			s_nxt.mod = 1'b0;
		end else begin
			unique case (s_r.st)
				S_IDLE: begin
					// activation at zero reading
					if (hot) begin
						s_nxt.cnt = '0;
						s_nxt.st = (s_r.ratio == RATIO_MIN) ? S_GATE : S_DN_STOP;
						s_nxt.mod = (s_r.ratio == RATIO_MIN);
					end
				end
				S_DN_STOP: begin
					// clocks held off, ratio drops at the end
					s_nxt.cnt = s_r.cnt + 1'b1;
					if (s_r.cnt == CNT_W'(STOP_CYC - 1)) begin
						s_nxt.ratio = s_r.ratio - 8'h01;
						s_nxt.st = S_DN_VOLT;
					end
				end
				S_DN_VOLT: begin
					// clocks run again, voltage follows
					s_nxt.vcode = vc_of(s_r.ratio);
					s_nxt.cnt = '0;
					s_nxt.st = S_WAIT;
				end
				S_WAIT: begin
					// check the reading after each step
					s_nxt.cnt = s_r.cnt + 1'b1;
					if (TEMP_HOT5 && s_r.ratio != RATIO_MIN) begin
						s_nxt.ratio = RATIO_MIN;
						s_nxt.vcode = vc_of(RATIO_MIN);
						s_nxt.mod = 1'b1;
						s_nxt.st = S_COMB;
					end else if (!hot) begin
						s_nxt.cnt = '0;
						s_nxt.st = S_HYST;
					end else if (s_r.cnt == CNT_W'(STEP_CYC - 1)) begin
						s_nxt.cnt = '0;
						if (s_r.ratio == RATIO_MIN) begin
							s_nxt.mod = 1'b1;
							s_nxt.st = S_GATE;
						end else begin
							s_nxt.st = S_DN_STOP;
						end
					end
				end
				S_GATE: begin
					// minimum ratio with modulation
					if (!hot) begin
						s_nxt.cnt = '0;
						s_nxt.st = S_HYST;
					end
				end
				S_COMB: begin
					// combined state ends without hysteresis
					if (!hot) begin
						s_nxt.mod = 1'b0;
						s_nxt.st = S_UP_VOLT;
					end
				end
				S_HYST: begin
					// cooled: wait out the hysteresis timer
					s_nxt.cnt = s_r.cnt + 1'b1;
					if (hot) begin
						s_nxt.cnt = '0;
						s_nxt.st = (s_r.mod) ? S_GATE : S_WAIT;
					end else if (s_r.cnt == CNT_W'(HYST_CYC - 1)) begin
						s_nxt.mod = 1'b0;
						s_nxt.st = (s_r.ratio == RATIO_NOM) ? S_IDLE : S_UP_VOLT;
					end
				end
				S_UP_VOLT: begin
					// voltage rises ahead of the ratio
					s_nxt.vcode = vc_of(s_r.ratio + 8'h01);
					s_nxt.cnt = '0;
					s_nxt.st = S_UP_STOP;
				end
				S_UP_STOP: begin
					// clocks off while ratio climbs one step
					s_nxt.cnt = s_r.cnt + 1'b1;
					if (s_r.cnt == CNT_W'(STOP_CYC - 1)) begin
						s_nxt.ratio = s_r.ratio + 8'h01;
						s_nxt.cnt = '0;
						if (hot) begin
							s_nxt.st = S_WAIT;
						end else if (s_r.ratio + 8'h01 == RATIO_NOM) begin
							s_nxt.st = S_IDLE;
						end else begin
							s_nxt.st = S_UP_VOLT;
						end
					end
				end
				S_EXT: begin
					// pin released: climb back step by step
					s_nxt.st = S_UP_VOLT;
				end
				default: begin
					s_nxt.st = S_IDLE;
				end
			endcase
		end
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			s_r <= RST_S;
		end else if (CE) begin
			s_r <= s_nxt;
		end
	end

	// outputs; snoop and interrupt logic is not gated here
	assign CLK_STOP = (s_r.st == S_DN_STOP) || (s_r.st == S_UP_STOP) || mif.gate || s_r.trip;
	assign THERMAL_TRIP_N = !s_r.trip;
	assign PROC_HOT_N_O = 1'b0;
	assign PROC_HOT_N_OE = drive;
	assign RATIO = s_r.ratio;
	assign VCODE = s_r.vcode;
	assign TCC_ACTIVE = (s_r.st != S_IDLE);
	assign PROC_HOT_EVT = s_r.ev_as || s_r.ev_de;
	assign HRDATA = s_r.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N || !CE);

	chk_trip_shut: assert property (TEMP_CATA |=> !THERMAL_TRIP_N && CLK_STOP)
		else $error("trip not asserted after catastrophic heat");
	chk_hot_drive: assert property ((s_r.st == S_IDLE) && hot && !ext && !s_r.lock
		&& !s_r.ctrl[CTRL_INONLY] |=> PROC_HOT_N_OE)
		else $error("hot pin not driven on activation");
	chk_step_time: assert property ($rose(s_r.st == S_DN_STOP) |-> ##[1:250] !CLK_STOP)
		else $error("ratio step longer than allowed");
	chk_volt_first: assert property ((s_r.st == S_UP_VOLT) && !ext && !s_r.lock
		|=> $stable(RATIO) && (VCODE == vc_of(RATIO + 8'h01)))
		else $error("ratio raised before voltage code");
	chk_ext_min: assert property (ext |=> (RATIO == RATIO_MIN) && !s_r.mod)
		else $error("external hot did not force minimum");
	chk_gate_min: assert property (mif.gate |-> RATIO == RATIO_MIN)
		else $error("modulation above minimum ratio");
	chk_crit_set: assert property (comb_act && (s_r.ccnt == CNT_W'(CRIT_CYC)) |=> s_r.crit)
		else $error("critical flag not set");
	chk_lock_hold: assert property (s_r.lock ##1 s_r.lock |-> RATIO == RATIO_MIN)
		else $error("lock did not hold minimum");
	chk_off_limit: assert property (mif.gate |-> s_r.offc < CNT_W'(OFF_MAX_CYC))
		else $error("clock off interval too long");
	chk_comb_jump: assert property ((s_r.st == S_WAIT) && TEMP_HOT5 && !ext && !s_r.lock
		&& (RATIO != RATIO_MIN) |=> s_r.mod && (RATIO == RATIO_MIN))
		else $error("no jump to combined state");

	cov_gating: cover property (s_r.st == S_WAIT ##1 s_r.st == S_GATE);
	cov_critical: cover property ($rose(s_r.crit));
	cov_external: cover property ($rose(s_r.st == S_EXT));

endmodule : tht_throttle
`default_nettype wire

// ==== tht_hot_partner.sv ====
// platform side model that pulls the shared hot pin low on request
`timescale 1ns/1ps
`default_nettype none
module tht_hot_partner #(
	parameter int GAP = 30 // least spacing of two assertions
)(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic req,   // bench wants the pin held low
	input  wire logic fast,  // bench allows a spacing violation
	output logic      drv_oe // model pulls the pin low
);
	int gap_cnt; // cycles until another assertion is allowed

	// open-drain driver with spacing guard
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			drv_oe  <= 1'b0;
			gap_cnt <= 0;
		end else begin
			if (gap_cnt != 0)
				gap_cnt <= gap_cnt - 1;
			if (req && !drv_oe && (gap_cnt == 0 || fast)) begin
				drv_oe  <= 1'b1;
				gap_cnt <= GAP;
			end else if (!req && drv_oe) begin
				drv_oe <= 1'b0;
			end
		end
	end
endmodule : tht_hot_partner
`default_nettype wire

// ==== tht_throttle_test.sv ====
// self-checking bench for the adaptive thermal throttle
`timescale 1ns/1ps
`default_nettype none
module tht_throttle_test;
	import tht_pkg::*;
	localparam logic [7:0] RNOM = 8'h0a; // short ratio table
	localparam logic [7:0] RMIN = 8'h08;
	localparam logic [7:0] VNOM = 8'h50;
	localparam logic [7:0] VSTP = 8'h02;
	localparam int STEP = 20;
	localparam int HYST = 10;
	localparam int TOG  = 30;
	localparam int PER  = 10;
	localparam int OFF  = 4;
	logic        clk = 1'b0;        // core clock
	logic        rst_n = 1'b0;      // sync reset
	logic        hsel = 1'b0;       // bus master side
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0]  temp_off = 8'h10;  // sensor starts cool
	logic        hot5 = 1'b0;
	logic        cata = 1'b0;
	logic        req = 1'b0;        // partner control
	logic        fast = 1'b0;
	logic        ce = 1'b1;         // clock enable
	wire  [31:0] hrdata;
	wire  [7:0]  ratio;
	wire  [7:0]  vcode;
	wire         hready, hresp, oe, pout, ext_oe, trip_n, stop, thermal_control_circuit, evt;
	wire         pin_n = !((oe && !pout) || ext_oe); // pulled-up shared pin
	logic [63:0] expq[$];           // pending reads {mask, value}
	logic [63:0] e;
	logic        rd_dp = 1'b0;      // read data phase under way
	logic [7:0]  rprev = RNOM;
	logic [31:0] seed = 32'h45f4401c;
	logic [31:0] a;
	logic        oe_seen;
	int          failures = 0;
	int          total_checks = 0;
	int          lo, hi, wn;

	tht_throttle #(.RATIO_NOM(RNOM), .RATIO_MIN(RMIN), .VC_NOM(VNOM), .VC_STEP(VSTP),
		.STEP_CYC(STEP), .HYST_CYC(HYST), .CRIT_CYC(50), .TOG_CYC(TOG),
		.MOD_PER(PER), .MOD_OFF(OFF)) i_tht_throttle (
		.CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.TEMP_OFF(temp_off), .TEMP_HOT5(hot5), .TEMP_CATA(cata), .PROC_HOT_N_I(pin_n),
		.PROC_HOT_N_O(pout), .PROC_HOT_N_OE(oe), .THERMAL_TRIP_N(trip_n),
		.CLK_STOP(stop), .RATIO(ratio), .VCODE(vcode), .TCC_ACTIVE(thermal_control_circuit),
		.PROC_HOT_EVT(evt));
	tht_hot_partner #(.GAP(TOG)) i_tht_hot_partner (.clk(clk), .rst_n(rst_n),
		.req(req), .fast(fast), .drv_oe(ext_oe));

	// 125 MHz clock
	always #4 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim();
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	// xorshift source for cool readings and bus data
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// status word from its fields
	function automatic logic [31:0] st(input logic [3:0] s, input logic [7:0] r,
			input logic [7:0] v, input logic [7:0] f);
		return {4'h0, s, v, r, f};
	endfunction : st

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// one single transfer; reads leave a note for the monitor
	task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] d,
			input logic [31:0] m);
		int n;
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= ad;
		hwrite <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		if (wr)
			hwdata <= d;
		else
			expq.push_back({m, d & m});
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 200);
		if (n >= 200) begin
			failures++;
			end_sim();
		end
	endtask : bus

	// lengths of the next clock-on gap and clock-off run
	task automatic runs(output int l, output int h);
		l = 0;
		h = 0;
		oe_seen = 1'b0;
		// first sample off the edge, so a run ending now is counted
		#1;
		while (stop !== 1'b1 && l < 3000) begin
			@(negedge clk);
			l++;
		end
		while (stop === 1'b1 && h < 3000) begin
			oe_seen = oe_seen | oe;
			@(negedge clk);
			h++;
		end
		if (l >= 3000 || h >= 3000) begin
			failures++;
			end_sim();
		end
	endtask : runs

	// bounded wait on active flag (0) or trip output (1)
	task automatic wsig(input int s, input logic v);
		logic x;
		wn = 0;
		x = ~v;
		while (x !== v && wn < 3000) begin
			@(negedge clk);
			wn++;
			x = (s == 0) ? thermal_control_circuit : trip_n;
		end
		if (wn >= 3000) begin
			failures++;
			end_sim();
		end
	endtask : wsig

	// compare each read data phase with the oldest note
	always @(posedge clk) begin
		if (rd_dp && expq.size() > 0) begin
			e = expq.pop_front();
			chk(hrdata & e[63:32], e[31:0]);
			chk(hresp, 1'b0);
		end
		rd_dp <= hsel && htrans[1] && !hwrite && hready;
	end

	// a ratio may only rise onto a voltage code that already suits it
	always @(negedge clk) begin
		if (rst_n === 1'b1 && ratio > rprev)
			chk(vcode, VNOM - (RNOM - ratio) * VSTP);
		rprev = ratio;
	end

	// hang guard
	initial begin
		#800000;
		failures++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// reset values and unmapped space
		bus(1'b0, 32'h0, {29'h0, CTRL_RST}, 32'hffffffff);
		bus(1'b0, 32'h4, st(4'h0, RNOM, VNOM, 8'h00), 32'h0fffffff);
		a = 32'h100 | (xs() & 32'hf0);
		bus(1'b1, a, xs(), 32'h0);
		bus(1'b0, a, 32'h0, 32'hffffffff);
		chk(trip_n, 1'b1);
		// heat: step down to the lowest ratio, then modulation
		@(posedge clk);
		temp_off <= 8'h00;
		runs(lo, hi);
		chk(hi, STOP_CYC);
		chk(hi <= TRANS_CYC, 1'b1);
		chk(oe_seen, 1'b1);
		tick(3);
		chk(ratio, RNOM - 8'h01);
		chk(vcode, VNOM - VSTP);
		runs(lo, hi);
		// three low samples went before this run, plus the voltage cycle
		chk(lo + 3, STEP + 1);
		runs(lo, hi);
		chk(hi, OFF);
		bus(1'b0, 32'h4, st(4'h4, RMIN, 8'(VNOM - 2 * VSTP), 8'h18), 32'h0fffff18);
		bus(1'b1, 32'h4, 32'hffffffff, 32'h0);
		runs(lo, hi);
		runs(lo, hi);
		chk(hi, OFF);
		chk(lo, PER - OFF);
		chk(hi * 8 <= 32000, 1'b1);
		// clock enable low freezes the modulation phase
		@(posedge clk);
		ce <= 1'b0;
		tick(1);
		a = {31'h0, stop};
		lo = 0;
		repeat (12) begin
			@(negedge clk);
			if (stop !== a[0])
				lo++;
		end
		chk(lo, 0);
		@(posedge clk);
		ce <= 1'b1;
		// random cool readings, hysteresis and recovery
		@(posedge clk);
		temp_off <= 8'h01 | 8'(xs());
		wsig(0, 1'b0);
		chk(wn > HYST, 1'b1);
		chk(ratio, RNOM);
		chk(vcode, VNOM);
		chk(stop, 1'b0);
		// overshoot while stepping jumps to the combined mode
		@(posedge clk);
		temp_off <= 8'h00;
		runs(lo, hi);
		@(posedge clk);
		hot5 <= 1'b1;
		tick(2);
		bus(1'b0, 32'h4, st(4'h5, RMIN, 8'h00, 8'h18), 32'h0f00ff18);
		tick(30);
		bus(1'b0, 32'h4, 32'h0, 32'h1);
		tick(40);
		bus(1'b0, 32'h4, 32'h1, 32'h1);
		runs(lo, hi);
		@(posedge clk);
		temp_off <= 8'h01 | 8'(xs());
		hot5 <= 1'b0;
		runs(lo, hi);
		chk(lo < HYST, 1'b1);
		chk(hi, STOP_CYC);
		wsig(0, 1'b0);
		bus(1'b0, 32'h4, 32'h1, 32'h1);
		bus(1'b1, 32'h4, 32'h1, 32'h0);
		bus(1'b0, 32'h4, 32'h0, 32'h1);
		// input-only pin with both event enables
		bus(1'b1, 32'h0, 32'h7, 32'h0);
		@(posedge clk);
		temp_off <= 8'h00;
		runs(lo, hi);
		chk(oe_seen, 1'b0);
		@(posedge clk);
		temp_off <= 8'h01 | 8'(xs());
		wsig(0, 1'b0);
		// platform asserts the pin
		@(posedge clk);
		req <= 1'b1;
		wsig(0, 1'b1);
		tick(3);
		chk(ratio, RMIN);
		chk(evt, 1'b1);
		bus(1'b0, 32'h4, st(4'h9, RMIN, 8'h00, 8'h2a), 32'h0f00ffff);
		lo = 0;
		repeat (40) begin
			@(negedge clk);
			if (stop !== 1'b0)
				lo++;
		end
		chk(lo, 0);
		chk(thermal_control_circuit, 1'b1);
		@(posedge clk);
		req <= 1'b0;
		wsig(0, 1'b0);
		bus(1'b0, 32'h4, 32'h6, 32'h6);
		bus(1'b1, 32'h4, 32'h6, 32'h0);
		tick(2);
		chk(evt, 1'b0);
		// two assertions too close together lock the minimum point
		fast <= 1'b1;
		repeat (2) begin
			@(posedge clk);
			req <= 1'b1;
			tick(6);
			@(posedge clk);
			req <= 1'b0;
			tick(6);
		end
		tick(20);
		bus(1'b0, 32'h4, st(4'h0, RMIN, 8'h00, 8'h40), 32'h0000ff40);
		chk(thermal_control_circuit, 1'b1);
		// catastrophic heat trips and stays tripped
		@(posedge clk);
		cata <= 1'b1;
		wsig(1, 1'b0);
		chk(stop, 1'b1);
		@(posedge clk);
		cata <= 1'b0;
		tick(5);
		chk(trip_n, 1'b0);
		bus(1'b0, 32'h4, 32'h80, 32'h80);
		// second reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		tick(3);
		@(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		chk(trip_n, 1'b1);
		chk(ratio, RNOM);
		bus(1'b0, 32'h0, 32'h0, 32'h7);
		end_sim();
	end
endmodule : tht_throttle_test
`default_nettype wire
